//--- verilog/psc_top.sv
// Purpose: Switch, pull-down, overvoltage and interrupt control
// Assumes: Comparator and pin inputs are asynchronous levels
// Notes: Registers are reached only through the I2C slave
`timescale 1ns/1ns
module psc_top
  import psc_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic SCL,
  input wire logic SDA,
  output logic SDA_DRIVE,
  output logic SDA_EN,
  output logic IRQ_OUT_N,
  output logic IRQ_OUT_N_EN,
  input wire logic VDD_VALID,
  input wire logic CC_OV,
  input wire logic SBU_OV,
  input wire logic FTR_PULLED_DOWN,
  input wire logic MOIST_ACTIVE,
  output logic CC_SW_CLOSE,
  output logic SBU_SW_CLOSE,
  output logic CC_PULLDOWN_EN,
  output logic FTR_TO_SBU1,
  output logic FTR_TO_SBU2
);
  psc_async_s async_raw, async_s;
  psc_req_s req;
  logic [7:0] rdata;

  logic ctrl_q, ctrl_d;
  logic [2:0] swctl_q, swctl_d;
  logic [3:0] mask_q, mask_d;
  logic [SRST_W-1:0] srst_cnt_q, srst_cnt_d;
  logic strap_q, strap_d;
  logic srst_hit;

  logic [3:0] int_q, int_d;
  logic [3:0] ev;
  logic cc_ov_p_q, sbu_ov_p_q;
  logic int_rd;

  logic cc_close_q, cc_close_d;
  logic sbu_close_q, sbu_close_d;
  logic pd_q, pd_d;
  logic ftr1_q, ftr1_d;
  logic ftr2_q, ftr2_d;
  logic auto_ok, cc_want, sbu_want;

  // Comparator, strap and bus pins into the clock domain
  assign async_raw = '{
    cc_ov: CC_OV,
    sbu_ov: SBU_OV,
    vdd_ok: VDD_VALID,
    ftr_pd: FTR_PULLED_DOWN,
    moist: MOIST_ACTIVE,
    scl: SCL,
    sda: SDA
  };

  psc_sync #(
    .W($bits(psc_async_s))
  ) u_sync (
    .clk(CLK),
    .rst(RST),
    .d(async_raw),
    .q(async_s)
  );

  psc_i2c u_i2c (
    .clk(CLK),
    .rst(RST),
    .scl(async_s.scl),
    .sda(async_s.sda),
    .rdata(rdata),
    .req(req),
    .sda_en(SDA_EN)
  );

  assign SDA_DRIVE = 1'b0;
  assign IRQ_OUT_N = 1'b0;
  // Pin held low while any pending bit stands
  assign IRQ_OUT_N_EN = |int_q;

  assign srst_hit = req.wr && req.addr == REG_SRST && req.wdata[SRST_BIT];

  // Register read mux
  always_comb begin
    rdata = 8'h00;
    unique case (req.addr)
      REG_CTRL: rdata = {7'h00, ctrl_q};
      REG_SWCTL: rdata = {5'h00, swctl_q};
      REG_INT: rdata = {4'h0, int_q};
      REG_MASK: rdata = {4'h0, mask_q};
      REG_STAT: rdata = {3'h0, async_s.moist, strap_q, async_s.vdd_ok,
                         async_s.sbu_ov, async_s.cc_ov};
      default: rdata = 8'h00;
    endcase
  end

  // Control registers, soft reset and strap capture
  always_comb begin
    ctrl_d = ctrl_q;
    swctl_d = swctl_q;
    mask_d = mask_q;
    strap_d = strap_q;
    srst_cnt_d = srst_cnt_q;
    if (srst_cnt_q != '0) begin
      srst_cnt_d = srst_cnt_q - 1'b1;
    end
    // Strap settles through the synchroniser before the count ends
    if (srst_cnt_q == SRST_W'(1)) begin
      strap_d = async_s.ftr_pd;
    end
    if (srst_hit) begin
      ctrl_d = CTRL_RST;
      swctl_d = SWCTL_RST;
      mask_d = MASK_RST;
      srst_cnt_d = SRST_CYCLES;
    end else if (req.wr) begin
      unique case (req.addr)
        REG_CTRL: ctrl_d = req.wdata[CTRL_MANUAL_BIT];
        REG_SWCTL: swctl_d = req.wdata[2:0];
        REG_MASK: mask_d = req.wdata[3:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_q <= CTRL_RST;
      swctl_q <= SWCTL_RST;
      mask_q <= MASK_RST;
      strap_q <= 1'b1;
      srst_cnt_q <= SRST_CYCLES;
    end else begin
      ctrl_q <= ctrl_d;
      swctl_q <= swctl_d;
      mask_q <= mask_d;
      strap_q <= strap_d;
      srst_cnt_q <= srst_cnt_d;
    end
  end

  // Overvoltage events and sticky interrupt bits
  assign int_rd = req.rd && req.addr == REG_INT;

  always_comb begin
    ev = 4'h0;
    ev[INT_CC_OV] = async_s.cc_ov && !cc_ov_p_q;
    ev[INT_SBU_OV] = async_s.sbu_ov && !sbu_ov_p_q;
    ev[INT_CC_REC] = !async_s.cc_ov && cc_ov_p_q;
    ev[INT_SBU_REC] = !async_s.sbu_ov && sbu_ov_p_q;
    if (srst_hit) begin
      int_d = INT_RST;
    end else begin
      // New event wins over a clearing read
      int_d = (int_q & ~{4{int_rd}}) | (ev & ~mask_q);
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      int_q <= INT_RST;
      cc_ov_p_q <= 1'b0;
      sbu_ov_p_q <= 1'b0;
    end else begin
      int_q <= int_d;
      cc_ov_p_q <= async_s.cc_ov;
      sbu_ov_p_q <= async_s.sbu_ov;
    end
  end

  // Switch paths, dead-battery pull-down and test pin routing
  // Soft reset write opens the paths in its own cycle
  assign auto_ok = async_s.vdd_ok && srst_cnt_q == '0 && !srst_hit;
  assign cc_want = ctrl_q ? swctl_q[SW_CC_BIT] : 1'b1;
  assign sbu_want = ctrl_q ? swctl_q[SW_SBU_BIT] : 1'b1;

  always_comb begin
    // Path state follows live overvoltage, no interrupt service needed
    cc_close_d = auto_ok && !async_s.cc_ov && !async_s.moist && cc_want;
    sbu_close_d = auto_ok && !async_s.sbu_ov && !async_s.moist && sbu_want
                  && strap_q;
    ftr1_d = auto_ok && !strap_q && !async_s.sbu_ov && !async_s.moist
             && !swctl_q[SW_FTR2_BIT];
    ftr2_d = auto_ok && !strap_q && !async_s.sbu_ov && !async_s.moist
             && swctl_q[SW_FTR2_BIT];
    pd_d = !async_s.vdd_ok;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cc_close_q <= 1'b0;
      sbu_close_q <= 1'b0;
      pd_q <= 1'b1;
      ftr1_q <= 1'b0;
      ftr2_q <= 1'b0;
    end else begin
      cc_close_q <= cc_close_d;
      sbu_close_q <= sbu_close_d;
      pd_q <= pd_d;
      ftr1_q <= ftr1_d;
      ftr2_q <= ftr2_d;
    end
  end

  assign CC_SW_CLOSE = cc_close_q;
  assign SBU_SW_CLOSE = sbu_close_q;
  assign CC_PULLDOWN_EN = pd_q;
  assign FTR_TO_SBU1 = ftr1_q;
  assign FTR_TO_SBU2 = ftr2_q;

  // Checks
  power_close_a: assert property (@(posedge CLK) disable iff (RST)
    async_s.vdd_ok && srst_cnt_q == '0 && !srst_hit && !async_s.cc_ov
    && !async_s.moist && !ctrl_q
    |=> CC_SW_CLOSE)
    else $error("CC switch not closed with valid supply");

  uvlo_open_a: assert property (@(posedge CLK) disable iff (RST)
    !async_s.vdd_ok |=> !CC_SW_CLOSE && !SBU_SW_CLOSE && CC_PULLDOWN_EN)
    else $error("Switches closed or pull-down absent under undervoltage");

  pd_release_a: assert property (@(posedge CLK) disable iff (RST)
    $rose(async_s.vdd_ok) |=> !CC_PULLDOWN_EN)
    else $error("Pull-down kept after supply became valid");

  srst_open_a: assert property (@(posedge CLK) disable iff (RST)
    srst_hit |=> (!CC_SW_CLOSE && !SBU_SW_CLOSE && !ctrl_q && mask_q == MASK_RST) [*8])
    else $error("Soft reset did not open switches or restore defaults");

  cc_ov_open_a: assert property (@(posedge CLK) disable iff (RST)
    async_s.cc_ov |=> !CC_SW_CLOSE)
    else $error("CC switch closed during CC overvoltage");

  sbu_only_a: assert property (@(posedge CLK) disable iff (RST)
    async_s.sbu_ov && !async_s.cc_ov && auto_ok && !async_s.moist && !ctrl_q
    |=> !SBU_SW_CLOSE && CC_SW_CLOSE)
    else $error("SBU overvoltage disturbed CC or left SBU closed");

  ov_flag_a: assert property (@(posedge CLK) disable iff (RST)
    $rose(async_s.cc_ov) && !mask_q[INT_CC_OV] && !srst_hit
    |=> int_q[INT_CC_OV] && IRQ_OUT_N_EN)
    else $error("CC overvoltage did not raise interrupt");

  recover_a: assert property (@(posedge CLK) disable iff (RST)
    $fell(async_s.cc_ov) && auto_ok && !async_s.moist && !ctrl_q && !srst_hit
    |=> CC_SW_CLOSE && (int_q[INT_CC_REC] || mask_q[INT_CC_REC]))
    else $error("No reclose or recovery interrupt after CC overvoltage");

  irq_hold_a: assert property (@(posedge CLK) disable iff (RST)
    IRQ_OUT_N_EN && !int_rd && !srst_hit |=> IRQ_OUT_N_EN)
    else $error("Interrupt released without register read");

  mask_block_a: assert property (@(posedge CLK) disable iff (RST)
    mask_q[INT_SBU_OV] && !int_q[INT_SBU_OV] |=> !int_q[INT_SBU_OV])
    else $error("Masked interrupt bit was set");

  manual_a: assert property (@(posedge CLK) disable iff (RST)
    ctrl_q && auto_ok && !async_s.cc_ov && !async_s.moist
    |=> CC_SW_CLOSE == $past(swctl_q[SW_CC_BIT]))
    else $error("Manual CC setting not applied");

  moist_open_a: assert property (@(posedge CLK) disable iff (RST)
    async_s.moist |=> !CC_SW_CLOSE && !SBU_SW_CLOSE)
    else $error("Switch closed while moisture detection runs");

  pd_off_a: assert property (@(posedge CLK) disable iff (RST)
    async_s.vdd_ok |=> !CC_PULLDOWN_EN)
    else $error("Pull-down present with valid supply");

  cc_only_a: assert property (@(posedge CLK) disable iff (RST)
    async_s.cc_ov && !async_s.sbu_ov && auto_ok && strap_q && !async_s.moist && !ctrl_q
    |=> !CC_SW_CLOSE && SBU_SW_CLOSE)
    else $error("CC overvoltage disturbed SBU or left CC closed");

  sbu_ov_open_a: assert property (@(posedge CLK) disable iff (RST)
    async_s.sbu_ov |=> !SBU_SW_CLOSE && !FTR_TO_SBU1 && !FTR_TO_SBU2)
    else $error("SBU path closed during SBU overvoltage");

  sbu_flag_a: assert property (@(posedge CLK) disable iff (RST)
    $rose(async_s.sbu_ov) && !mask_q[INT_SBU_OV] && !srst_hit
    |=> int_q[INT_SBU_OV] && IRQ_OUT_N_EN)
    else $error("SBU overvoltage did not raise interrupt");

  sbu_recover_a: assert property (@(posedge CLK) disable iff (RST)
    $fell(async_s.sbu_ov) && auto_ok && strap_q && !async_s.moist && !ctrl_q
    |=> SBU_SW_CLOSE && (int_q[INT_SBU_REC] || mask_q[INT_SBU_REC]))
    else $error("No reclose or recovery interrupt after SBU overvoltage");

  read_clear_a: assert property (@(posedge CLK) disable iff (RST)
    int_rd && !srst_hit && $stable(async_s.cc_ov) && $stable(async_s.sbu_ov)
    |=> !IRQ_OUT_N_EN)
    else $error("Interrupt still pending after register read");

  strap_normal_a: assert property (@(posedge CLK) disable iff (RST)
    strap_q |=> !FTR_TO_SBU1 && !FTR_TO_SBU2)
    else $error("Test pin routed with pulled-down strap");

  ftr_default_a: assert property (@(posedge CLK) disable iff (RST)
    !strap_q && auto_ok && !async_s.sbu_ov && !async_s.moist && !swctl_q[SW_FTR2_BIT]
    |=> FTR_TO_SBU1 && !FTR_TO_SBU2 && !SBU_SW_CLOSE)
    else $error("Test pin not routed to first SBU line");

  ftr_second_a: assert property (@(posedge CLK) disable iff (RST)
    !strap_q && auto_ok && !async_s.sbu_ov && !async_s.moist && swctl_q[SW_FTR2_BIT]
    |=> FTR_TO_SBU2 && !FTR_TO_SBU1 && !SBU_SW_CLOSE)
    else $error("Test pin not routed to second SBU line");
endmodule : psc_top

//--- verilog/psc_pkg.sv
// Purpose: Shared constants and types for the protection switch control
// Assumes: CLK at 250 MHz, registers reached over the I2C management port
// Notes: Register offsets other than soft reset are local choices
// Overview of operation
// - Close CC and SBU after POR
// - Undervoltage opens switches and presents pull-down
// - Pull-down until supply valid, then close CC
// - Soft reset bit restores defaults, reopens switches
// - Overvoltage opens affected path promptly
// - CC overvoltage opens CC only
// - SBU overvoltage opens SBU only
// - Overvoltage sets status bit, interrupt low
// - Recovery recloses path, raises recovery interrupt
// - Reclose independent of interrupt service
// - Test pin routes to SBU1 or SBU2
// - Pulled-down test pin enables normal SBU
// - Manual mode overrides automatic switch control
// - Manual cannot close during moisture or overvoltage
// - Interrupt stays low until register read
// - Mask bits default clear, block setting
package psc_pkg;
  localparam int unsigned CLK_MHZ = 250;
  // Device address on the management bus
  localparam logic [6:0] I2C_DEV_ADDR = 7'h28;

  localparam logic [7:0] REG_CTRL = 8'h01;
  localparam logic [7:0] REG_SWCTL = 8'h03;
  localparam logic [7:0] REG_INT = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h05;
  localparam logic [7:0] REG_STAT = 8'h07;
  localparam logic [7:0] REG_SRST = 8'h0B;

  localparam int CTRL_MANUAL_BIT = 0;
  localparam int SW_CC_BIT = 0;
  localparam int SW_SBU_BIT = 1;
  localparam int SW_FTR2_BIT = 2;
  localparam int INT_CC_OV = 0;
  localparam int INT_SBU_OV = 1;
  localparam int INT_CC_REC = 2;
  localparam int INT_SBU_REC = 3;
  localparam int SRST_BIT = 0;

  localparam logic CTRL_RST = 1'h0;
  localparam logic [2:0] SWCTL_RST = 3'h3;
  localparam logic [3:0] INT_RST = 4'h0;
  localparam logic [3:0] MASK_RST = 4'h0;

  // Momentary open time after any reset
  localparam int unsigned SRST_OPEN_NS = 1000;
  localparam int SRST_W = 9;
  localparam logic [SRST_W-1:0] SRST_CYCLES =
    SRST_W'((SRST_OPEN_NS * CLK_MHZ + 999) / 1000);

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } psc_req_s;

  typedef struct packed {
    logic cc_ov;
    logic sbu_ov;
    logic vdd_ok;
    logic ftr_pd;
    logic moist;
    logic scl;
    logic sda;
  } psc_async_s;

  typedef enum logic [4:0] {
    I2C_IDLE = 5'h01,
    I2C_RX = 5'h02,
    I2C_ACK = 5'h04,
    I2C_TX = 5'h08,
    I2C_TACK = 5'h10
  } psc_i2c_e;
endpackage : psc_pkg

//--- verilog/psc_sync.sv
// Purpose: Two-stage synchroniser for asynchronous inputs
// Assumes: Inputs are levels
// Notes: First stage feeds only the second stage
`timescale 1ns/1ns
module psc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        meta_q[i] <= 1'b0;
        q[i] <= 1'b0;
      end else begin
        meta_q[i] <= d[i];
        q[i] <= meta_q[i];
      end
    end
  end
endmodule : psc_sync

//--- verilog/psc_i2c.sv
// Purpose: I2C slave giving byte access to the register file
// Assumes: scl and sda already synchronised to clk
// Notes: Pointer auto-increments on each data byte
`timescale 1ns/1ns
module psc_i2c
  import psc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic [7:0] rdata,
  output psc_req_s req,
  output logic sda_en
);
  psc_i2c_e st_q, st_d;
  logic scl_q, sda_q;
  logic [7:0] sr_q, sr_d, ptr_q, ptr_d;
  logic [3:0] cnt_q, cnt_d;
  logic [1:0] idx_q, idx_d;
  logic rw_q, rw_d, nack_q, nack_d;
  logic scl_rise, scl_fall, start, stop;

  assign scl_rise = scl && !scl_q;
  assign scl_fall = !scl && scl_q;
  assign start = scl && scl_q && sda_q && !sda;
  assign stop = scl && scl_q && !sda_q && sda;
  assign sda_en = (st_q == I2C_ACK) || (st_q == I2C_TX && !sr_q[7]);

  always_comb begin
    st_d = st_q;
    sr_d = sr_q;
    ptr_d = ptr_q;
    cnt_d = cnt_q;
    idx_d = idx_q;
    rw_d = rw_q;
    nack_d = nack_q;
    req = '{wr: 1'b0, rd: 1'b0, addr: ptr_q, wdata: sr_q};
    if (stop) begin
      st_d = I2C_IDLE;
    end else if (start) begin
      st_d = I2C_RX;
      cnt_d = 4'h0;
      idx_d = 2'h0;
    end else begin
      unique case (st_q)
        I2C_IDLE: begin
        end
        I2C_RX: begin
          if (scl_rise) begin
            sr_d = {sr_q[6:0], sda};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            st_d = I2C_ACK;
            cnt_d = 4'h0;
            if (idx_q == 2'h0) begin
              rw_d = sr_q[0];
              if (sr_q[7:1] != I2C_DEV_ADDR) begin
                st_d = I2C_IDLE;
              end
            end else if (idx_q == 2'h1) begin
              ptr_d = sr_q;
            end else begin
              req.wr = 1'b1;
              ptr_d = ptr_q + 8'h01;
            end
            if (idx_q != 2'h2) begin
              idx_d = idx_q + 2'h1;
            end
          end
        end
        I2C_ACK: begin
          if (scl_fall) begin
            if (rw_q) begin
              st_d = I2C_TX;
              sr_d = rdata;
              req.rd = 1'b1;
              ptr_d = ptr_q + 8'h01;
            end else begin
              st_d = I2C_RX;
            end
          end
        end
        I2C_TX: begin
          if (scl_fall) begin
            if (cnt_q == 4'h7) begin
              st_d = I2C_TACK;
            end else begin
              sr_d = {sr_q[6:0], 1'b0};
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        I2C_TACK: begin
          if (scl_rise) begin
            nack_d = sda;
          end else if (scl_fall) begin
            if (nack_q) begin
              st_d = I2C_IDLE;
            end else begin
              st_d = I2C_TX;
              cnt_d = 4'h0;
              sr_d = rdata;
              req.rd = 1'b1;
              ptr_d = ptr_q + 8'h01;
            end
          end
        end
        default: begin
          st_d = I2C_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= I2C_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sr_q <= 8'h00;
      ptr_q <= 8'h00;
      cnt_q <= 4'h0;
      idx_q <= 2'h0;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
    end else begin
      st_q <= st_d;
      scl_q <= scl;
      sda_q <= sda;
      sr_q <= sr_d;
      ptr_q <= ptr_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      rw_q <= rw_d;
      nack_q <= nack_d;
    end
  end
endmodule : psc_i2c

//--- test/psc_host.sv
// Purpose: Host processor model on the I2C management port
// Assumes: SDA has a pull-up; sda_en high pulls it low
// Notes: Pins change only at falling CLK edges; bit period 5*Q cycles
`timescale 1ns/1ns
module psc_host
  import psc_pkg::*;
#(
  parameter int Q = 126
) (
  input wire logic clk,
  input wire logic sda_in,
  output logic scl,
  output logic sda_en,
  output logic nack_seen,
  output logic rd_valid,
  output logic [7:0] rd_byte
);
  initial begin
    scl = 1'h1;
    sda_en = 1'h0;
    nack_seen = 1'h0;
    rd_valid = 1'h0;
    rd_byte = 8'h00;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt
  // Low 3Q, high 2Q: just under 400 kHz
  task automatic bit_io(input logic b, output logic r);
    sda_en = !b;
    wt(Q);
    scl = 1'h1;
    wt(Q);
    r = sda_in;
    wt(Q);
    scl = 1'h0;
    wt(2 * Q);
  endtask : bit_io
  task automatic start();
    sda_en = 1'h0;
    wt(Q);
    scl = 1'h1;
    wt(2 * Q);
    sda_en = 1'h1;
    wt(2 * Q);
    scl = 1'h0;
    wt(Q);
  endtask : start
  task automatic stop();
    sda_en = 1'h1;
    wt(Q);
    scl = 1'h1;
    wt(2 * Q);
    sda_en = 1'h0;
    wt(4 * Q);
  endtask : stop
  task automatic send_byte(input logic [7:0] b);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(b[i], a);
    bit_io(1'h1, a);
    if (a) nack_seen = 1'h1;
  endtask : send_byte
  task automatic recv_byte(input logic last);
    logic [7:0] d;
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(1'h1, d[i]);
    bit_io(last, a);
    rd_byte = d;
    rd_valid = 1'h1;
    wt(1);
    rd_valid = 1'h0;
  endtask : recv_byte
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d, input int n);
    start();
    send_byte({I2C_DEV_ADDR, 1'h0});
    send_byte(a);
    for (int k = n - 1; k >= 0; k--) send_byte(d[8*k +: 8]);
    stop();
  endtask : write_reg
  task automatic read_reg(input logic [7:0] a);
    start();
    send_byte({I2C_DEV_ADDR, 1'h0});
    send_byte(a);
    start();
    send_byte({I2C_DEV_ADDR, 1'h1});
    recv_byte(1'h1);
    stop();
  endtask : read_reg
endmodule : psc_host

//--- test/psc_top_bench.sv
// Purpose: Self-checking bench for the protection switch control
// Assumes: Host model drives I2C; comparator inputs driven here
// Notes: Read bytes are compared through an expectation queue
`timescale 1ns/1ns
module psc_top_bench;
  import psc_pkg::*;
  logic clk, rst, vdd, cc_ov, sbu_ov, ftr_pd, moist;
  logic sda_drv, sda_en, irq_n, irq_en, cc_cl, sbu_cl, pd_en, ftr1, ftr2;
  logic scl, h_sda_en, nack, rd_valid;
  logic [7:0] rd_byte;
  logic [7:0] exp_q[$];
  wire logic sda_w = sda_en ? sda_drv : !h_sda_en;
  wire logic irq_pin = irq_en ? irq_n : 1'h1;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  int open_len = 0;
  psc_top i_psc_top (.CLK(clk), .RST(rst), .SCL(scl), .SDA(sda_w), .SDA_DRIVE(sda_drv),
    .SDA_EN(sda_en), .IRQ_OUT_N(irq_n), .IRQ_OUT_N_EN(irq_en), .VDD_VALID(vdd),
    .CC_OV(cc_ov), .SBU_OV(sbu_ov), .FTR_PULLED_DOWN(ftr_pd), .MOIST_ACTIVE(moist),
    .CC_SW_CLOSE(cc_cl), .SBU_SW_CLOSE(sbu_cl), .CC_PULLDOWN_EN(pd_en),
    .FTR_TO_SBU1(ftr1), .FTR_TO_SBU2(ftr2));
  psc_host i_psc_host (.clk(clk), .sda_in(sda_w), .scl(scl), .sda_en(h_sda_en),
    .nack_seen(nack), .rd_valid(rd_valid), .rd_byte(rd_byte));
  initial begin
    clk = 1'h0;
    forever #2 clk = !clk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  // Raise an overvoltage input and hold it for a random width; caller samples while held, then releases it
  task automatic ov_hold(input logic is_cc);
    if (is_cc) cc_ov = 1'h1;
    else sbu_ov = 1'h1;
    cyc(5 + $urandom_range(0, 20));
  endtask : ov_hold
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (!cc_cl && !sbu_cl) open_len <= open_len + 1;
    if (cycles == 150000) begin
      mismatches++;
      final_report();
    end
  end
  initial begin
    forever begin
      @(posedge rd_valid);
      if (exp_q.size() == 0) begin
        mismatches++;
        $display("ERROR read_extra expected none seen %h", rd_byte);
      end else begin
        check("read_byte", exp_q.pop_front(), rd_byte);
      end
    end
  end
  initial begin
    void'($urandom(65681));
    rst = 1'h1;
    vdd = 1'h1;
    cc_ov = 1'h0;
    sbu_ov = 1'h0;
    ftr_pd = 1'h1;
    moist = 1'h0;
    cyc(16);
    rst = 1'h0;
    cyc(260);
    check("cc_close", 1'h1, cc_cl);
    check("sbu_close", 1'h1, sbu_cl);
    check("pulldown", 1'h0, pd_en);
    check("ftr_sbu1", 1'h0, ftr1);
    ov_hold(1'h1);
    check("cc_close", 1'h0, cc_cl);
    check("sbu_close", 1'h1, sbu_cl);
    check("irq_pin", 1'h0, irq_pin);
    cc_ov = 1'h0;
    cyc(5);
    check("cc_close", 1'h1, cc_cl);
    ov_hold(1'h0);
    check("sbu_close", 1'h0, sbu_cl);
    check("cc_close", 1'h1, cc_cl);
    sbu_ov = 1'h0;
    cyc(200);
    check("sbu_close", 1'h1, sbu_cl);
    check("irq_pin", 1'h0, irq_pin);
    exp_q.push_back(8'h0f);
    i_psc_host.read_reg(REG_INT);
    check("irq_pin", 1'h1, irq_pin);
    i_psc_host.write_reg(REG_MASK, 16'h0005, 1);
    ov_hold(1'h1);
    check("cc_close", 1'h0, cc_cl);
    cc_ov = 1'h0;
    cyc(5);
    check("irq_pin", 1'h1, irq_pin);
    open_len = 0;
    i_psc_host.write_reg(REG_SRST, 16'h0001, 1);
    check("open_len", 1'h1, open_len >= SRST_CYCLES && open_len <= SRST_CYCLES + 4);
    check("cc_close", 1'h1, cc_cl);
    ov_hold(1'h1);
    check("irq_pin", 1'h0, irq_pin);
    cc_ov = 1'h0;
    vdd = 1'h0;
    cyc(5);
    check("cc_close", 1'h0, cc_cl);
    check("sbu_close", 1'h0, sbu_cl);
    check("pulldown", 1'h1, pd_en);
    vdd = 1'h1;
    cyc(300);
    check("cc_close", 1'h1, cc_cl);
    check("pulldown", 1'h0, pd_en);
    ftr_pd = 1'h0;
    rst = 1'h1;
    cyc(4);
    rst = 1'h0;
    cyc(260);
    check("ftr_sbu1", 1'h1, ftr1);
    check("ftr_sbu2", 1'h0, ftr2);
    check("sbu_close", 1'h0, sbu_cl);
    i_psc_host.write_reg(8'h02, 16'hff06, 2);
    i_psc_host.write_reg(REG_CTRL, 16'h0001, 1);
    check("cc_close", 1'h0, cc_cl);
    check("ftr_sbu2", 1'h1, ftr2);
    check("ftr_sbu1", 1'h0, ftr1);
    moist = 1'h1;
    cyc(5);
    check("ftr_sbu2", 1'h0, ftr2);
    check("nack", 1'h0, nack);
    check("queue_left", 8'h00, 8'(exp_q.size()));
    final_report();
  end
endmodule : psc_top_bench
